// ===== rtl/spi_mem_port.sv
`timescale 1ns/10ps
`include "spi_mem_defines.svh"

module spi_mem_port
   import spi_mem_pkg::*;
#(
   parameter int ADDR_W     = `MEM_ADDR_W,
   parameter int FIFO_DEPTH = `WR_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // Serial pins from the master
   input  wire logic cs_b,
   input  wire logic sck,
   input  wire logic mosi,
   input  wire logic hold_b,
   input  wire logic wp_b,
   // Serial output, enable high while driving
   output logic      so,
   output logic      so_oe
);
   import spi_mem_pkg::*;

   // Address field is three bytes wide
   if (ADDR_W < 1 || ADDR_W > `ADDR_FIELD_W) begin : g_chk
      $error("spi_mem_port ADDR_W must lie between 1 and 24");
   end

   typedef struct packed {
      pins_s                    meta;      // First sync stage
      pins_s                    pin;       // Second sync stage
      logic                     sck_prev;  // For edge detection
      logic                     cs_prev;   // For select edges
      port_state_e              mode;      // Sequencer state
      logic [2:0]               bit_cnt;   // Bits taken in this byte
      logic [1:0]               addr_cnt;  // Address bytes taken
      logic [7:0]               shreg;     // Incoming byte
      logic [7:0]               cmd;       // Accepted command code
      logic [`ADDR_FIELD_W-1:0] addr;      // Burst address
      logic                     wl;        // Write latch flag
      logic                     prot_en;   // Status protect enable
      logic [1:0]               bp;        // Block protect bits, stored only
      logic                     sleeping;  // Sleep entered
      logic                     drv;       // Read data loaded
      logic [7:0]               out_sh;    // Outgoing byte
      logic                     push;      // Write word waiting for buffer
      wr_word_s                 wword;     // That word
      logic                     so;        // Output data
      logic                     so_oe;     // Output enable
   } port_state_s;

   port_state_s st;
   port_state_s next_st;
   logic        sck_rise;    // Rising serial clock seen
   logic        sck_fall;    // Falling serial clock seen
   logic        cs_fall;     // Select asserted
   logic        cs_rise;     // Select released
   logic        run;         // Not paused
   logic [7:0]  in_byte;     // Byte completed on this rise
   logic [7:0]  status;      // Status byte as read
   logic [7:0]  rd_q;        // Array data at burst address
   logic        fifo_ready;  // Buffer can take a word
   wr_word_s    drain_word;  // Oldest buffered write
   logic        drain_valid; // Buffer holds a write
   logic [7:0]  mem [1 << ADDR_W];  // Byte array

   // Edges come from the second sync stage only
   assign sck_rise = st.pin.sck && !st.sck_prev;
   assign sck_fall = !st.pin.sck && st.sck_prev;
   assign cs_fall  = !st.pin.cs_b && st.cs_prev;
   assign cs_rise  = st.pin.cs_b && !st.cs_prev;
   assign run      = st.pin.hold_b;
   assign in_byte  = {st.shreg[6:0], st.pin.mosi};

   // Status byte; unused bits read fixed
   always_comb begin
      status                = 8'h00;
      status[`ST_PROT_BIT]  = st.prot_en;
      status[`ST_ONE_BIT]   = 1'b1;
      status[`ST_BP1_BIT]   = st.bp[1];
      status[`ST_BP0_BIT]   = st.bp[0];
      status[`ST_WL_BIT]    = st.wl;
   end

   // Sequencer; pauses freeze framing and data, while sync stages, edge history, buffer handoff and output enable still move
   always_comb begin
      next_st          = st;
      next_st.meta     = '{cs_b, sck, mosi, hold_b, wp_b};
      next_st.pin      = st.meta;
      next_st.sck_prev = st.pin.sck;
      next_st.cs_prev  = st.pin.cs_b;
      if (st.push && fifo_ready) begin
         next_st.push = 1'b0;
      end
      if (!run) begin
         // Edges during a pause are dropped, not deferred
      end else if (st.pin.cs_b) begin
         next_st.mode = ST_OFF;
         next_st.drv  = 1'b0;
         if (cs_rise) begin
            if (st.cmd == `CMD_CLR_WL || st.cmd == `CMD_ST_WR ||
                st.cmd == `CMD_WRITE) begin
               next_st.wl = 1'b0;
            end
            if (st.cmd == `CMD_SLEEP) begin
               next_st.sleeping = 1'b1;
            end
         end
      end else if (cs_fall) begin
         // Fresh framing for each select period
         next_st.bit_cnt  = 3'd0;
         next_st.addr_cnt = 2'd0;
         next_st.cmd      = 8'h00;
         next_st.sleeping = 1'b0;
         // A waking select carries no command
         next_st.mode     = st.sleeping ? ST_IGNORE : ST_CMD;
      end else if (sck_rise) begin
         // Sample data input on rising edges only
         next_st.shreg   = in_byte;
         next_st.bit_cnt = st.bit_cnt + 3'd1;
         unique case (st.mode)
            ST_CMD: begin
               if (st.bit_cnt == `LAST_BIT) begin
                  // Decode the command table
                  next_st.cmd  = in_byte;
                  next_st.mode = ST_IGNORE;
                  if (in_byte == `CMD_SET_WL) begin
                     next_st.wl = 1'b1;
                  end else if (in_byte == `CMD_ST_RD) begin
                     next_st.mode = ST_SREAD;
                  end else if (in_byte == `CMD_ST_WR) begin
                     next_st.mode = ST_SWRITE;
                  end else if (in_byte == `CMD_READ ||
                               (in_byte == `CMD_WRITE && st.wl)) begin
                     next_st.mode = ST_ADDR;
                  end
               end
            end
            ST_ADDR: begin
               next_st.addr = {st.addr[`ADDR_FIELD_W-2:0], st.pin.mosi};
               if (st.bit_cnt == `LAST_BIT) begin
                  next_st.addr_cnt = st.addr_cnt + 2'd1;
                  if (st.addr_cnt == `ADDR_BYTES - 2'd1) begin
                     next_st.mode = (st.cmd == `CMD_READ) ? ST_RDATA : ST_WDATA;
                  end
               end
            end
            ST_WDATA: begin
               if (st.bit_cnt == `LAST_BIT) begin
                  // Protect pin plays no part here
                  next_st.push  = 1'b1;
                  next_st.wword = '{st.addr, in_byte};
                  next_st.addr  = st.addr + 24'd1;
               end
            end
            ST_SWRITE: begin
               if (st.bit_cnt == `LAST_BIT) begin
                  next_st.mode = ST_IGNORE;
                  if (st.wl && !(st.prot_en && !st.pin.wp_b)) begin
                     next_st.prot_en = in_byte[`ST_PROT_BIT];
                     next_st.bp      = {in_byte[`ST_BP1_BIT], in_byte[`ST_BP0_BIT]};
                  end
               end
            end
            ST_RDATA, ST_SREAD, ST_IGNORE, ST_OFF: begin
               // Later command bytes are not decoded
            end
            default: begin
               next_st.mode = ST_IGNORE;
            end
         endcase
      end else if (sck_fall && (st.mode == ST_RDATA || st.mode == ST_SREAD)) begin
         // Output moves only after a falling edge
         next_st.drv = 1'b1;
         if (st.bit_cnt == 3'd0) begin
            if (st.mode == ST_RDATA) begin
               next_st.so     = rd_q[7];
               next_st.out_sh = {rd_q[6:0], 1'b0};
               next_st.addr   = st.addr + 24'd1;
            end else begin
               next_st.so     = status[7];
               next_st.out_sh = {status[6:0], 1'b0};
            end
         end else begin
            next_st.so     = st.out_sh[7];
            next_st.out_sh = {st.out_sh[6:0], 1'b0};
         end
      end
      // Drive only with read data loaded, selected and not paused
      next_st.so_oe = next_st.drv && !st.pin.cs_b && st.pin.hold_b &&
                      (next_st.mode == ST_RDATA || next_st.mode == ST_SREAD);
   end

   // State register; the whole state is plain flip-flops
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st          <= '0;
         st.meta     <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
         st.pin      <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
         st.cs_prev  <= 1'b1;
         st.mode     <= ST_OFF;
      end else begin
         st <= next_st;
      end
   end

   // Array read follows the burst address, ready long before a fall
   always_ff @(posedge clk) begin
      rd_q <= mem[st.addr[ADDR_W-1:0]];
   end

   // Drain buffered writes; a pause stalls the array side
   always_ff @(posedge clk) begin
      if (drain_valid && run) begin
         mem[drain_word.addr[ADDR_W-1:0]] <= drain_word.data;
      end
   end

   // Write buffer between the serial side and the array
   byte_fifo #(
      .WIDTH ($bits(wr_word_s)),
      .DEPTH (FIFO_DEPTH)
   ) u_wr_fifo (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_data   (st.wword),
      .in_valid  (st.push),
      .in_ready  (fifo_ready),
      .out_data  (drain_word),
      .out_valid (drain_valid),
      .out_ready (run)
   );

   assign so    = st.so;
   assign so_oe = st.so_oe;

   a_standby_hiz: assert property (@(posedge clk) disable iff (!rst_b)
      st.pin.cs_b |=> !so_oe) else $error("output driven while deselected");
   a_pause_hiz: assert property (@(posedge clk) disable iff (!rst_b)
      !st.pin.hold_b |=> !so_oe) else $error("output driven while paused");
   a_oe_read_only: assert property (@(posedge clk) disable iff (!rst_b)
      so_oe |-> (st.mode == ST_RDATA || st.mode == ST_SREAD))
      else $error("output driven outside a read");
   a_so_on_fall: assert property (@(posedge clk) disable iff (!rst_b)
      (so != $past(so)) |-> $past(sck_fall) && $past(run))
      else $error("output moved without a falling edge");
   a_pause_freeze: assert property (@(posedge clk) disable iff (!rst_b)
      !run |=> $stable(st.bit_cnt) && $stable(st.mode) && $stable(st.addr))
      else $error("state moved during pause");
   a_cmd_once: assert property (@(posedge clk) disable iff (!rst_b)
      (st.mode != ST_CMD && !(cs_fall && run)) |=> st.mode != ST_CMD)
      else $error("second command byte decoded");
   a_wl_set_cause: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(st.wl) |-> $past(st.mode) == ST_CMD && $past(st.bit_cnt) == 3'd7 &&
      $past(in_byte) == `CMD_SET_WL) else $error("write latch set without command");
   a_input_on_rise: assert property (@(posedge clk) disable iff (!rst_b)
      (st.shreg != $past(st.shreg)) |-> $past(sck_rise))
      else $error("data input taken off a rising edge");
   a_burst_step: assert property (@(posedge clk) disable iff (!rst_b)
      (run && !st.pin.cs_b && !cs_fall && sck_rise && st.mode == ST_WDATA &&
       st.bit_cnt == 3'd7) |=> st.push && st.addr == $past(st.addr) + 24'd1)
      else $error("write byte not queued or address not advanced");
   a_write_drains: assert property (@(posedge clk) disable iff (!rst_b)
      (st.push && run) |-> ##[0:12] !st.push)
      else $error("write word not taken by buffer");

endmodule

// ===== rtl/spi_mem_defines.svh
`ifndef SPI_MEM_DEFINES_SVH
`define SPI_MEM_DEFINES_SVH

// Command codes, taken from the first byte of a select period
`define CMD_SET_WL   8'h06
`define CMD_CLR_WL   8'h04
`define CMD_ST_RD    8'h05
`define CMD_ST_WR    8'h01
`define CMD_READ     8'h03
`define CMD_WRITE    8'h02
`define CMD_SLEEP    8'hb9

// Array geometry
`define MEM_ADDR_W   18
`define ADDR_FIELD_W 24
`define ADDR_BYTES   2'd3
`define LAST_BIT     3'd7

// Status byte layout
`define ST_PROT_BIT  7
`define ST_ONE_BIT   6
`define ST_BP1_BIT   3
`define ST_BP0_BIT   2
`define ST_WL_BIT    1

// Write buffer depth
`define WR_FIFO_DEPTH 8

// Serial clock limit and local clock rate, in MHz
`define SCK_MAX_MHZ  40
`define CLK_MHZ      200

`endif

// ===== rtl/spi_mem_pkg.sv
`include "spi_mem_defines.svh"

package spi_mem_pkg;

   // Port sequencer states, one-hot
   typedef enum logic [7:0] {
      ST_OFF    = 8'h01,
      ST_CMD    = 8'h02,
      ST_ADDR   = 8'h04,
      ST_WDATA  = 8'h08,
      ST_RDATA  = 8'h10,
      ST_SREAD  = 8'h20,
      ST_SWRITE = 8'h40,
      ST_IGNORE = 8'h80
   } port_state_e;

   // Pin levels sampled together
   typedef struct packed {
      logic cs_b;
      logic sck;
      logic mosi;
      logic hold_b;
      logic wp_b;
   } pins_s;

   // One buffered array write
   typedef struct packed {
      logic [`ADDR_FIELD_W-1:0] addr;
      logic [7:0]               data;
   } wr_word_s;

endpackage

// ===== rtl/byte_fifo.sv
`timescale 1ns/10ps

module byte_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // Filling side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // Draining side
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int PW = $clog2(DEPTH);

   // Pointer arithmetic relies on natural wrap
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("byte_fifo depth must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [PW-1:0] wr_ptr;   // Next slot to fill
      logic [PW-1:0] rd_ptr;   // Oldest entry
      logic [PW:0]   count;    // Entries held
   } fifo_state_s;

   fifo_state_s    st;
   fifo_state_s    next_st;
   logic [WIDTH-1:0] store [DEPTH];   // Entry storage
   logic           push;
   logic           pop;

   // Honest flags straight from the count
   assign in_ready  = (st.count != DEPTH[PW:0]);
   assign out_valid = (st.count != '0);
   assign out_data  = store[st.rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Next pointers and count
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.wr_ptr = st.wr_ptr + 1'b1;
      end
      if (pop) begin
         next_st.rd_ptr = st.rd_ptr + 1'b1;
      end
      next_st.count = st.count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Storage needs no reset; empty entries are never read out
   always_ff @(posedge clk) begin
      if (push) begin
         store[st.wr_ptr] <= in_data;
      end
   end

endmodule

// ===== bench/spi_host_model.sv
`timescale 1ns/10ps

module spi_host_model (
   // Serial pins toward the port
   output logic      cs_b,
   output logic      sck,
   output logic      mosi,
   output logic      hold_b,
   output logic      wp_b,
   // Serial output back from the port
   input  wire logic so,
   input  wire logic so_oe
);
   localparam realtime HALF = 62.5; // Half of the 125 ns link period
   logic               mode3;       // Clock idle level of the open frame

   // Pins idle: deselected, not paused, protect released
   initial begin
      cs_b   = 1'b1;
      sck    = 1'b0;
      mosi   = 1'b0;
      hold_b = 1'b1;
      wp_b   = 1'b1;
      mode3  = 1'b0;
   end

   // Clock and data wiggle while deselected; nothing may react
   task automatic noise();
      repeat (8) begin
         sck  = ~sck;
         mosi = ~mosi;
         #(HALF);
      end
   endtask

   // Open a frame with the clock parked at the chosen idle level
   task automatic sel(input logic m3);
      mode3 = m3;
      sck   = m3;
      #(HALF);
      cs_b  = 1'b0;
      #(HALF);
   endtask

   // One byte; data set while the clock is low, answer taken at the rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck   = 1'b0;
         mosi  = tx[i];
         #(HALF);
         sck   = 1'b1;
         rx[i] = so_oe ? so : ~so; // A floating line reads as the inverse of its last level
         #(HALF / 2);
         mosi  = ~tx[i]; // Moves while the clock is high must not count
         #(HALF / 2);
      end
   endtask

   // Close the frame; in mode 0 the clock returns low first
   task automatic desel();
      if (!mode3) begin
         sck = 1'b0;
         #(HALF);
      end
      cs_b = 1'b1;
      mosi = ~mosi; // Data line means nothing once deselected
      #(4 * HALF);
   endtask

   // Pause between bytes; pause moves only with the clock low
   task automatic pause(output logic oe_in_hold);
      sck    = 1'b0;
      #(HALF);
      hold_b = 1'b0;
      #(HALF);
      oe_in_hold = so_oe;
      sck    = 1'b1; // Clock and select edges while paused are dropped
      cs_b   = 1'b1;
      #(HALF);
      sck    = 1'b0;
      cs_b   = 1'b0;
      #(HALF);
      hold_b = 1'b1;
      #(HALF);
   endtask
endmodule

// ===== bench/tb_spi_mem_port.sv
`timescale 1ns/10ps
`include "spi_mem_defines.svh"

`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin err_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end

module tb_spi_mem_port;
   logic clk;         // 200 MHz local clock
   logic rst_b;       // Synchronous reset, active low
   logic cs_b;        // Pins from the host model
   logic sck;
   logic mosi;
   logic hold_b;
   logic wp_b;
   logic so;          // Serial output and its enable
   logic so_oe;
   logic oe_seen;     // Set when the output drove at any time
   int   err_count;   // Mismatches
   int   check_count; // Comparisons made

   spi_mem_port u_spi_mem_port (
      .clk    (clk),
      .rst_b  (rst_b),
      .cs_b   (cs_b),
      .sck    (sck),
      .mosi   (mosi),
      .hold_b (hold_b),
      .wp_b   (wp_b),
      .so     (so),
      .so_oe  (so_oe)
   );

   spi_host_model u_spi_host_model (
      .cs_b   (cs_b),
      .sck    (sck),
      .mosi   (mosi),
      .hold_b (hold_b),
      .wp_b   (wp_b),
      .so     (so),
      .so_oe  (so_oe)
   );

   // Clock
   always #2.5 clk = ~clk;

   // Remember any drive of the output since the last clear
   always @(posedge clk) begin
      if (so_oe === 1'b1) begin
         oe_seen <= 1'b1;
      end
   end

   // Single-byte frame, mode 0
   task automatic one_cmd(input logic [7:0] code);
      logic [7:0] d;
      u_spi_host_model.sel(1'b0);
      u_spi_host_model.xfer(code, d);
      u_spi_host_model.desel();
   endtask

   // Two-byte frame, mode 3; returns what came back with the second byte
   task automatic frame2(input logic [7:0] code, input logic [7:0] tx, output logic [7:0] rx);
      logic [7:0] d;
      u_spi_host_model.sel(1'b1);
      u_spi_host_model.xfer(code, d);
      u_spi_host_model.xfer(tx, rx);
      u_spi_host_model.desel();
   endtask

   // Open a frame with an opcode and a three-byte address, MSB first
   task automatic open_addr(input logic m3, input logic [7:0] code, input logic [23:0] a);
      logic [7:0] d;
      u_spi_host_model.sel(m3);
      u_spi_host_model.xfer(code, d);
      for (int i = 2; i >= 0; i--) begin
         u_spi_host_model.xfer(a[8*i +: 8], d);
      end
   endtask

   // Deselected noise leaves the port quiet and the latch clear
   task automatic test_standby();
      logic [7:0] d;
      `CHK("oe after reset", 1'b0, so_oe)
      oe_seen = 1'b0;
      u_spi_host_model.noise();
      `CHK("oe while deselected", 1'b0, oe_seen)
      frame2(`CMD_ST_RD, 8'h00, d);
      `CHK("status at power up", 8'h40, d)
      $display("test_standby done");
   endtask

   // Latch set by its command; a second opcode in one frame is ignored
   task automatic test_latch();
      logic [7:0] d;
      one_cmd(`CMD_SET_WL);
      frame2(`CMD_ST_RD, 8'h00, d);
      `CHK("latch set", 8'h42, d)
      frame2(`CMD_CLR_WL, `CMD_SET_WL, d);
      frame2(`CMD_ST_RD, 8'h00, d);
      `CHK("second opcode ignored", 8'h40, d)
      $display("test_latch done");
   endtask

   // Status writes: fixed bits kept, protect pin with enable set refuses
   task automatic test_status();
      logic [7:0] d;
      one_cmd(`CMD_SET_WL);
      frame2(`CMD_ST_WR, 8'hbf, d);
      frame2(`CMD_ST_RD, 8'h00, d);
      `CHK("status stored", 8'hcc, d)
      u_spi_host_model.wp_b = 1'b0;
      one_cmd(`CMD_SET_WL);
      frame2(`CMD_ST_WR, 8'h00, d);
      frame2(`CMD_ST_RD, 8'h00, d);
      `CHK("status guarded", 8'hcc, d)
      u_spi_host_model.wp_b = 1'b1;
      one_cmd(`CMD_SET_WL);
      frame2(`CMD_ST_WR, 8'h00, d);
      frame2(`CMD_ST_RD, 8'h00, d);
      `CHK("status cleared", 8'h40, d)
      $display("test_status done");
   endtask

   // Burst across the array top with pauses, read back at once in mode 3
   task automatic test_burst();
      logic [7:0] d;
      logic       oe;
      one_cmd(`CMD_SET_WL);
      u_spi_host_model.wp_b = 1'b0; // Protect pin must leave array writes alone
      open_addr(1'b0, `CMD_WRITE, 24'hfffffc);
      for (int k = 0; k < 10; k++) begin
         if (k == 4) begin
            u_spi_host_model.pause(oe);
            `CHK("oe in write pause", 1'b0, oe)
         end
         u_spi_host_model.xfer(8'hc3 + 8'(k), d);
      end
      u_spi_host_model.desel();
      u_spi_host_model.wp_b = 1'b1;
      frame2(`CMD_ST_RD, 8'h00, d);
      `CHK("latch after write", 8'h40, d)
      open_addr(1'b1, `CMD_READ, 24'h03fffc);
      for (int k = 0; k < 10; k++) begin
         if (k == 5) begin
            u_spi_host_model.pause(oe);
            `CHK("oe in read pause", 1'b0, oe)
         end
         u_spi_host_model.xfer(8'h00, d);
         `CHK("burst data", 8'hc3 + 8'(k), d)
      end
      u_spi_host_model.desel();
      `CHK("oe after deselect", 1'b0, so_oe)
      open_addr(1'b0, `CMD_WRITE, 24'h000000);
      u_spi_host_model.xfer(8'h00, d);
      u_spi_host_model.desel();
      open_addr(1'b0, `CMD_READ, 24'hfc0000);
      u_spi_host_model.xfer(8'h00, d);
      u_spi_host_model.desel();
      `CHK("write without latch", 8'hc7, d)
      $display("test_burst done");
   endtask

   // The frame after sleep only wakes the port
   task automatic test_sleep();
      logic [7:0] d;
      one_cmd(`CMD_SLEEP);
      one_cmd(`CMD_SET_WL);
      frame2(`CMD_ST_RD, 8'h00, d);
      `CHK("wake frame ignored", 8'h40, d)
      $display("test_sleep done");
   endtask

   // Counts, verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Hang guard; the run needs well under half of this
   initial begin
      #400000;
      err_count++;
      $display("[FAIL] run time expected done seen hung");
      tally_and_finish();
   end

   // Reset for four cycles, then the scenarios in turn
   initial begin
      clk         = 1'b0;
      rst_b       = 1'b0;
      oe_seen     = 1'b0;
      err_count   = 0;
      check_count = 0;
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      // Model steps are multiples of 31.25 ns; this offset keeps pin moves off clk edges
      #0.5;
      test_standby();
      test_latch();
      test_status();
      test_burst();
      test_sleep();
      tally_and_finish();
   end
endmodule
